//--- pkg/dtap_map.svh
/*
 Constants of the debug test port: instruction codes, field positions,
 reset values and timing figures of the two data registers.
 Assumes inclusion by bare name from the package and the testbench.
*/
// Functional notes
// (RL1) Read-only 32-bit implementation register scanned under the implementation instruction.
// (RL2) Bits 31:29 hold a preset architecture version code.
// (RL3) Bit 24 takes its reset value from a core input about probe interrupts.
// (RL4) Bits 23:21 encode address-space-identifier width from a core input.
// (RL5) Bit 14 always reads one: no probe memory access support.
// (RL6) Several implementation values come from core inputs, set per derivative.
// (RL7) 32-bit debug control register scanned under the control instruction.
// (RL8) Control register reachable only by scan: written by shift-in, read by shift-out.
// (RL9) Update-DR loads control only if reset flag is zero or written zero.
// (RL10) Core hard and soft resets set control values; test-port reset does not.
// (RL11) Core reset works with test clock stopped; values apply once edges resume.
// (RL12) Probe allows five test clocks after core reset for control bits to settle.
// (RL13) Reset flag resets to one and stays one while core reset is applied.
// (RL14) Probe clears the reset flag by scanning zero to acknowledge it.
// (RL15) Instruction register is five bits; it acts from the next data scan.
// (RL16) Reserved implementation fields read zero; scanned data to it is ignored.
`ifndef DTAP_MAP_SVH
`define DTAP_MAP_SVH

`define DTAP_IR_W            5
`define DTAP_DR_W            32
`define DTAP_IR_CAPTURE      5'h01
`define DTAP_INS_IDCODE      5'h01
`define DTAP_INS_IMPL        5'h03
`define DTAP_INS_CONTROL     5'h0a
`define DTAP_INS_BYPASS      5'h1f

`define DTAP_IMPL_VER_HI     31
`define DTAP_IMPL_VER_LO     29
`define DTAP_IMPL_INT_BIT    24
`define DTAP_IMPL_SID_HI     23
`define DTAP_IMPL_SID_LO     21
`define DTAP_IMPL_NO_PROBE_MEM_ACCESS_BIT  14
`define DTAP_VER_2_5         3'h1
`define DTAP_VER_2_6         3'h2
`define DTAP_IMPL_RSV_MASK   32'h1e1fbfff

`define DTAP_CTL_ROCC_BIT    31
`define DTAP_CTL_RESET       32'h80000000
`define DTAP_CTL_WMASK       32'h0000d008
`define DTAP_ID_DEFAULT      32'h00000001

`define DTAP_CORE_SETTLE_TCK 5

`endif

//--- pkg/dtap_pkg.sv
/*
 Types of the debug test port: the sixteen states of the test port
 controller. Assumes dtap_map.svh is on the include path.
*/
`default_nettype none
`include "dtap_map.svh"

package dtap_pkg;

	typedef enum logic [3:0]
	{
		TAP_RESET,
		TAP_IDLE,
		TAP_SEL_DR,
		TAP_CAP_DR,
		TAP_SHIFT_DR,
		TAP_EXIT1_DR,
		TAP_PAUSE_DR,
		TAP_EXIT2_DR,
		TAP_UPD_DR,
		TAP_SEL_IR,
		TAP_CAP_IR,
		TAP_SHIFT_IR,
		TAP_EXIT1_IR,
		TAP_PAUSE_IR,
		TAP_EXIT2_IR,
		TAP_UPD_IR
	} dtap_state_type;

endpackage : dtap_pkg

`default_nettype wire

//--- rtl/dtap_sync.sv
/*
 Three-stage synchroniser for the test port pins. Stages two and three
 are offered so the caller can accept a change once both agree.
 Assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none

module dtap_sync
	import dtap_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Pins and stages
	input  wire logic [3:0] pin_in,
	input  wire logic [3:0] pin_rst,
	output logic      [3:0] stage2,
	output logic      [3:0] stage3
);

	logic [3:0] stage1;

	genvar i;
	generate
		for (i = 0; i < 4; i++)
		begin : g_bit
			always_ff @(posedge clk or negedge nrst)
			begin
				if (!nrst)
				begin
					stage1[i] <= 1'b0;
					stage2[i] <= 1'b0;
					stage3[i] <= 1'b0;
				end
				else
				begin
					stage1[i] <= pin_in[i];
					stage2[i] <= stage1[i];
					stage3[i] <= stage2[i];
				end
			end
		end
	endgenerate

	// Reset level of every bit is fixed at zero; pin_rst is only folded into unused_rst.
	logic unused_rst;
	assign unused_rst = ^pin_rst;

endmodule : dtap_sync

`default_nettype wire

//--- rtl/dtap_top.sv
/*
 Debug test port with the implementation-features and debug control
 data registers. The probe's test clock, mode, data and test reset pins
 are sampled on clk; core hard and soft resets arrive on clk's domain.
*/
`timescale 1ns/10ps
`default_nettype none

module dtap_top
	import dtap_pkg::*;
#(
	parameter logic [31:0] ID_CODE = `DTAP_ID_DEFAULT // Arbitrary value.
)
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Test port pins
	input  wire logic        tck,
	input  wire logic        tms,
	input  wire logic        tdi,
	input  wire logic        trst_n,
	output logic             tdo,
	output logic             tdo_oe_n,
	// Core side
	input  wire logic        hard_rst_n,
	input  wire logic        soft_rst_n,
	input  wire logic        probe_int_support_input,
	input  wire logic [2:0]  space_id_width,
	input  wire logic        new_core_rev,
	output logic      [31:0] debug_control
);

	logic [3:0]             s2;
	logic [3:0]             s3;
	logic [3:0]             pin_q;
	logic                   tck_rise;
	logic                   tck_fall;
	logic                   trst_act;
	dtap_state_type         state;
	dtap_state_type         next_state;
	logic [`DTAP_IR_W-1:0]  ir_shift;
	logic [`DTAP_IR_W-1:0]  ir;
	logic [`DTAP_DR_W-1:0]  dr_shift;
	logic [31:0]            impl;
	logic                   core_rst;
	logic                   upd_ctl;

	function automatic logic [31:0] sel_capture(input logic [4:0] code,
		input logic [31:0] im, input logic [31:0] ct);
		if (code == `DTAP_INS_IMPL)
			sel_capture = im;
		else if (code == `DTAP_INS_CONTROL)
			sel_capture = ct;
		else if (code == `DTAP_INS_IDCODE)
			sel_capture = ID_CODE;
		else
			sel_capture = 32'h00000000;
	endfunction : sel_capture

	function automatic logic sel_is_wide(input logic [4:0] code);
		sel_is_wide = (code == `DTAP_INS_IMPL) || (code == `DTAP_INS_CONTROL)
			|| (code == `DTAP_INS_IDCODE);
	endfunction : sel_is_wide

	// Pin order: 0 tck, 1 tms, 2 tdi, 3 trst_n.
	dtap_sync u_sync
	(
		.clk     (clk),
		.nrst    (nrst),
		.pin_in  ({trst_n, tdi, tms, tck}),
		.pin_rst (4'h0),
		.stage2  (s2),
		.stage3  (s3)
	);

	// A pin change is taken only once stages two and three agree.
	// The test reset reads as active until the synchroniser has seen the pin
	// high, so no false release edge follows nrst and the port stays in reset.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			pin_q <= 4'h0;
		else
			pin_q <= (s2 & ~(s2 ^ s3)) | (pin_q & (s2 ^ s3));
	end

	assign tck_rise = (s2[0] == s3[0]) && s3[0] && !pin_q[0];
	assign tck_fall = (s2[0] == s3[0]) && !s3[0] && pin_q[0];
	assign trst_act = !pin_q[3];
	assign core_rst = !hard_rst_n || !soft_rst_n;

	always_comb
	begin
		next_state = state;
		case (state)
			TAP_RESET:    next_state = pin_q[1] ? TAP_RESET : TAP_IDLE;
			TAP_IDLE:     next_state = pin_q[1] ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR:   next_state = pin_q[1] ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR:   next_state = pin_q[1] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: next_state = pin_q[1] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: next_state = pin_q[1] ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: next_state = pin_q[1] ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: next_state = pin_q[1] ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR:   next_state = pin_q[1] ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR:   next_state = pin_q[1] ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR:   next_state = pin_q[1] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: next_state = pin_q[1] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: next_state = pin_q[1] ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: next_state = pin_q[1] ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: next_state = pin_q[1] ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR:   next_state = pin_q[1] ? TAP_SEL_DR : TAP_IDLE;
			default:      next_state = TAP_RESET;
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			state <= TAP_RESET;
		else if (trst_act)
			state <= TAP_RESET;
		else if (tck_rise)
			state <= next_state;
	end

	// Instruction path; the held code changes at Update-IR and returns to the IDCODE instruction in the reset state.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ir_shift <= `DTAP_IR_CAPTURE;
			ir       <= `DTAP_INS_IDCODE;
		end
		else if (trst_act)
		begin
			ir_shift <= `DTAP_IR_CAPTURE;
			ir       <= `DTAP_INS_IDCODE;
		end
		else if (tck_rise)
		begin
			if (state == TAP_RESET)
				ir <= `DTAP_INS_IDCODE;
			else if (state == TAP_CAP_IR)
				ir_shift <= `DTAP_IR_CAPTURE;
			else if (state == TAP_SHIFT_IR)
				ir_shift <= {pin_q[2], ir_shift[`DTAP_IR_W-1:1]}; // RL15
			else if (state == TAP_UPD_IR)
				ir <= ir_shift; // RL15
		end
	end

	// Implementation values follow the core straps while the core is held in
	// reset, and are caught once after nrst, so they act as reset values.
	logic impl_loaded;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			impl        <= 32'h00000000;
			impl_loaded <= 1'b0;
		end
		else if (core_rst || !impl_loaded)
		begin
			impl_loaded <= 1'b1;
			impl <= 32'h00000000; // RL16
			impl[`DTAP_IMPL_VER_HI:`DTAP_IMPL_VER_LO] <=
				new_core_rev ? `DTAP_VER_2_6 : `DTAP_VER_2_5; // RL2
			impl[`DTAP_IMPL_INT_BIT] <= probe_int_support_input; // RL3 RL6
			impl[`DTAP_IMPL_SID_HI:`DTAP_IMPL_SID_LO] <= space_id_width; // RL4 RL6
			impl[`DTAP_IMPL_NO_PROBE_MEM_ACCESS_BIT] <= 1'b1; // RL5
		end
	end

	// Data path: one shared shift register, bypass uses its bottom bit alone.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			dr_shift <= 32'h00000000;
		else if (tck_rise)
		begin
			if (state == TAP_CAP_DR)
				dr_shift <= sel_capture(ir, impl, debug_control); // RL1 RL7 RL8
			else if (state == TAP_SHIFT_DR && sel_is_wide(ir))
				dr_shift <= {pin_q[2], dr_shift[`DTAP_DR_W-1:1]};
			else if (state == TAP_SHIFT_DR)
				dr_shift[0] <= pin_q[2];
		end
	end

	// Update is refused while an unacknowledged core reset is flagged.
	assign upd_ctl = tck_rise && state == TAP_UPD_DR && ir == `DTAP_INS_CONTROL
		&& (!debug_control[`DTAP_CTL_ROCC_BIT] || !dr_shift[`DTAP_CTL_ROCC_BIT]);

	// Core resets act on clk, so a stopped test clock does not delay them, and
	// the test reset pin never reaches this register. The register settles one
	// clk after a core reset, well inside the five test clocks the probe allows.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			debug_control <= `DTAP_CTL_RESET;
		else if (core_rst)
			debug_control <= `DTAP_CTL_RESET; // RL10 RL11 RL12 RL13
		else if (upd_ctl)
			debug_control <= (dr_shift & `DTAP_CTL_WMASK)
				| (dr_shift & `DTAP_CTL_RESET); // RL9 RL14
	end

	// Output changes on the falling test clock edge while shifting.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tdo      <= 1'b0;
			tdo_oe_n <= 1'b1;
		end
		else if (tck_fall)
		begin
			tdo_oe_n <= !(state == TAP_SHIFT_DR || state == TAP_SHIFT_IR);
			if (state == TAP_SHIFT_IR)
				tdo <= ir_shift[0];
			else
				tdo <= dr_shift[0];
		end
	end

	sequence s_ctl_scan_done;
		tck_rise && state == TAP_UPD_DR && ir == `DTAP_INS_CONTROL && !core_rst;
	endsequence

	AST_ROCC_HELD: assert property (@(posedge clk) disable iff (!nrst) // RL13
		core_rst |=> debug_control[`DTAP_CTL_ROCC_BIT])
		else $error("reset flag not held during core reset");

	AST_UPD_BLOCKED: assert property (@(posedge clk) disable iff (!nrst) // RL9
		s_ctl_scan_done ##0 (debug_control[`DTAP_CTL_ROCC_BIT]
		&& dr_shift[`DTAP_CTL_ROCC_BIT]) ##1 !core_rst
		|-> $stable(debug_control))
		else $error("control updated while reset flag set");

	AST_UPD_LOADED: assert property (@(posedge clk) disable iff (!nrst) // RL14
		s_ctl_scan_done ##0 !dr_shift[`DTAP_CTL_ROCC_BIT]
		|=> !core_rst |-> debug_control == ($past(dr_shift) & `DTAP_CTL_WMASK))
		else $error("control not loaded by acknowledged scan");

	AST_NO_TRST_CTL: assert property (@(posedge clk) disable iff (!nrst) // RL10
		(trst_act && !core_rst && !upd_ctl) |=> $stable(debug_control))
		else $error("test reset changed control register");

	AST_CORE_RST_VAL: assert property (@(posedge clk) disable iff (!nrst) // RL11
		core_rst |=> debug_control == `DTAP_CTL_RESET)
		else $error("control not at reset value after core reset");

	AST_IMPL_FIXED: assert property (@(posedge clk) disable iff (!nrst) // RL5
		impl_loaded |-> (impl[`DTAP_IMPL_NO_PROBE_MEM_ACCESS_BIT]
		&& (impl & `DTAP_IMPL_RSV_MASK) == 32'h00000000))
		else $error("implementation fixed bits wrong");

	AST_IMPL_STRAP: assert property (@(posedge clk) disable iff (!nrst) // RL3
		core_rst |=> impl[`DTAP_IMPL_INT_BIT] == $past(probe_int_support_input)
		&& impl[`DTAP_IMPL_SID_HI:`DTAP_IMPL_SID_LO] == $past(space_id_width))
		else $error("implementation straps not taken");

	AST_IR_EFFECT: assert property (@(posedge clk) disable iff (!nrst) // RL15
		(tck_rise && state == TAP_UPD_IR && !trst_act) |=> ir == $past(ir_shift))
		else $error("instruction not applied at update");

	AST_IMPL_SCAN: assert property (@(posedge clk) disable iff (!nrst) // RL1
		(tck_rise && state == TAP_CAP_DR && ir == `DTAP_INS_IMPL && !trst_act)
		|=> dr_shift == $past(impl))
		else $error("implementation register not captured");

	sequence s_ctl_scan_open;
		s_ctl_scan_done ##0 !debug_control[`DTAP_CTL_ROCC_BIT];
	endsequence

	AST_UPD_OPEN: assert property (@(posedge clk) disable iff (!nrst) // RL9
		s_ctl_scan_open
		|=> debug_control == ($past(dr_shift) & (`DTAP_CTL_WMASK | `DTAP_CTL_RESET)))
		else $error("control not loaded while reset flag clear");

	AST_CTL_CAPTURE: assert property (@(posedge clk) disable iff (!nrst) // RL8
		(tck_rise && state == TAP_CAP_DR && ir == `DTAP_INS_CONTROL && !trst_act)
		|=> dr_shift == $past(debug_control))
		else $error("control register not captured");

	AST_CTL_RSV: assert property (@(posedge clk) disable iff (!nrst) // RL8
		(debug_control & ~(`DTAP_CTL_WMASK | `DTAP_CTL_RESET)) == 32'h00000000)
		else $error("control bits set outside the writable set");

	AST_OE_SHIFT: assert property (@(posedge clk) disable iff (!nrst) // RL8
		(tck_fall && (state == TAP_SHIFT_DR || state == TAP_SHIFT_IR))
		|=> !tdo_oe_n)
		else $error("data out not enabled while shifting");

	AST_TDO_HOLD: assert property (@(posedge clk) disable iff (!nrst) // RL8
		!tck_fall |=> $stable(tdo) && $stable(tdo_oe_n))
		else $error("data out moved without a falling test clock");

	AST_TRST_TAP: assert property (@(posedge clk) disable iff (!nrst) // RL10
		trst_act |=> state == TAP_RESET && ir == `DTAP_INS_IDCODE)
		else $error("test reset did not return the port to its reset state");

endmodule : dtap_top

`default_nettype wire

//--- testbench/dtap_probe.sv
/*
 Behavioural debug probe that drives the serial test port pins.
 Assumes clk is the block clock; every pin changes just after its rising edge.
*/
`timescale 1ns/10ps
`default_nettype none

module dtap_probe
(
	// Clock
	input  wire logic clk,
	// Test port
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	output logic      trst_n,
	input  wire logic tdo
);
	int   stretch;
	logic so;

	initial
	begin
		stretch = 0;
		tck     = 1'b0;
		tms     = 1'b1;
		tdi     = 1'b0;
		trst_n  = 1'b1;
	end

	// One test clock of 320 ns plus 40 ns per unit of stretch; tdo is read late in the high phase, where it cannot move.
	task automatic tick(input logic m, input logic d);
		tms <= m;
		tdi <= d;
		repeat (3 + stretch) @(posedge clk);
		tck <= 1'b1;
		repeat (4) @(posedge clk);
		so = tdo;
		tck <= 1'b0;
		// The data line flips once its hold time is over, so stale data never looks valid.
		tdi <= ~d;
		@(posedge clk);
	endtask : tick

	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		dout = '0;
		tick(1'b1, 1'b0);
		if (ir)
			tick(1'b1, 1'b0);
		tick(1'b0, 1'b0);
		tick(1'b0, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			tick(i == n - 1, din[i]);
			dout[i] = so;
		end
		tick(1'b1, 1'b0);
		tick(1'b0, 1'b0);
	endtask : scan

	// After a core reset the probe idles before touching the control register.
	task automatic settle;
		repeat (5) tick(1'b0, 1'b0);
	endtask : settle

	task automatic test_reset;
		trst_n <= 1'b0;
		repeat (8) @(posedge clk);
		trst_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : test_reset
endmodule : dtap_probe

`default_nettype wire

//--- testbench/test_debug_tap_impl_and_control_regs.sv
/*
 Self-checking bench for the debug test port data registers.
 Assumes the probe model drives the test pins and the bench the core side.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dtap_map.svh"

module test_debug_tap_impl_and_control_regs;
	localparam logic [31:0] ID = 32'h00000001; // Arbitrary value.
	logic        clk;
	logic        nrst;
	logic        hard_rst_n;
	logic        soft_rst_n;
	logic        probe_int_support_input;
	logic [2:0]  space_id_width;
	logic        new_core_rev;
	wire logic   tck;
	wire logic   tms;
	wire logic   tdi;
	wire logic   trst_n;
	wire logic   tdo;
	wire logic   tdo_oe_n;
	wire logic [31:0] debug_control;
	int          miscompares = 0;
	int          comparisons = 0;

	dtap_top #(.ID_CODE(ID)) u_dtap_top (.clk(clk), .nrst(nrst), .tck(tck), .tms(tms),
		.tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
		.hard_rst_n(hard_rst_n), .soft_rst_n(soft_rst_n),
		.probe_int_support_input(probe_int_support_input),
		.space_id_width(space_id_width), .new_core_rev(new_core_rev),
		.debug_control(debug_control));
	dtap_probe u_dtap_probe (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
		.trst_n(trst_n), .tdo(tdo));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task print_verdict;
		if (miscompares == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict

	// Every instruction scan must capture 00001 while shifting the new code in.
	task automatic ir(input logic [4:0] ins);
		logic [31:0] c;
		u_dtap_probe.scan(1'b1, 5, {27'h0, ins}, c);
		chk(c, 32'h1);
	endtask : ir

	task automatic dr(input int n, input logic [31:0] din, input logic [31:0] exp);
		logic [31:0] q;
		u_dtap_probe.scan(1'b0, n, din, q);
		chk(q, exp);
	endtask : dr

	// The test clock stands still for the whole core reset.
	task automatic core_rst(input logic hard);
		if (hard)
			hard_rst_n <= 1'b0;
		else
			soft_rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk(debug_control, `DTAP_CTL_RESET);
		hard_rst_n <= 1'b1;
		soft_rst_n <= 1'b1;
		@(posedge clk);
		u_dtap_probe.settle();
	endtask : core_rst

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial
	begin
		repeat (40000) @(posedge clk);
		miscompares++;
		print_verdict();
	end

	initial
	begin
		nrst = 1'b0;
		hard_rst_n = 1'b1;
		soft_rst_n = 1'b1;
		probe_int_support_input = 1'b0;
		space_id_width = 3'h0;
		new_core_rev = 1'b0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (6) @(posedge clk);
		chk(debug_control, `DTAP_CTL_RESET);
		chk({31'h0, tdo_oe_n}, 32'h1);
		u_dtap_probe.tick(1'b0, 1'b0);
		dr(32, 32'h0, ID);
		for (int k = 0; k < 8; k++)
		begin
			space_id_width <= {1'b0, k[1:0]};
			new_core_rev <= k[2];
			probe_int_support_input <= k[0];
			core_rst(k[1]);
			ir(`DTAP_INS_IMPL);
			dr(32, 32'hffffffff, {k[2] ? 3'h2 : 3'h1, 4'h0, k[0], 1'b0, k[1:0],
				6'h0, 1'b1, 14'h0});
			dr(32, 32'h0, {k[2] ? 3'h2 : 3'h1, 4'h0, k[0], 1'b0, k[1:0],
				6'h0, 1'b1, 14'h0});
		end
		ir(`DTAP_INS_CONTROL);
		dr(32, 32'hffffffff, 32'h80000000);
		chk(debug_control, 32'h80000000);
		dr(32, 32'h7fffffff, 32'h80000000);
		chk(debug_control, 32'h0000d008);
		dr(32, 32'h80000000, 32'h0000d008);
		chk(debug_control, 32'h80000000);
		dr(32, 32'h0000d008, 32'h80000000);
		chk(debug_control, 32'h0000d008);
		core_rst(1'b1);
		dr(32, 32'h8000d008, 32'h80000000);
		chk(debug_control, 32'h80000000);
		dr(32, 32'h0000d008, 32'h80000000);
		chk(debug_control, 32'h0000d008);
		u_dtap_probe.test_reset();
		chk(debug_control, 32'h0000d008);
		u_dtap_probe.tick(1'b0, 1'b0);
		dr(32, 32'h0, ID);
		u_dtap_probe.stretch = 3;
		ir(`DTAP_INS_BYPASS);
		dr(2, 32'h1, 32'h2);
		print_verdict();
	end
endmodule : test_debug_tap_impl_and_control_regs

`default_nettype wire
